// ===== hdl/dbs_consts.svh
/*
 * constants of the four-word burst ddr sram interface: widths, lane layout,
 * array size, burst length, buffer depth and clock figures.
 * assumes inclusion by bare name; guarded against double inclusion.
 */
`ifndef DBS_CONSTS_SVH
`define DBS_CONSTS_SVH

// data bus and byte lanes (wide configuration)
`define DBS_DQ_W        36
`define DBS_LANES       4
`define DBS_LANE_W      9
// address: row part from address_inputs, two burst start bits below it
`define DBS_ROW_W       17
`define DBS_LO_W        2
// rows kept in the modelled array
`define DBS_ARR_ROW_W   4
`define DBS_ARR_AW      6
// words in a burst
`define DBS_BURST_LEN   3'h4
// read data buffer
`define DBS_FIFO_DEPTH  8
// synchronised pin vector: 4 refs, 2 ctl, row, 2 start, data, lanes
`define DBS_SYNC_W      65
// core clock period in ns
`define DBS_CORE_NS     25

`endif

// ===== hdl/dbs_pkg.sv
/*
 * types of the four-word burst ddr sram interface.
 * assumes dbs_consts.svh is reachable by bare name.
 */
`include "dbs_consts.svh"

package dbs_pkg;

	// bus-cycle state, gray along idle -> write -> idle; idle <-> read flips both bits
	typedef enum logic [1:0]
	{
		DBS_ST_IDLE = 2'b00,
		DBS_ST_WR   = 2'b01,
		DBS_ST_RD   = 2'b11
	} dbs_state_e;

	// a loaded command
	typedef struct packed
	{
		logic [`DBS_ROW_W-1:0] row;
		logic [`DBS_LO_W-1:0]  start;
		logic                  rd;
	} dbs_cmd_s;

	// one write data edge with its lane masks
	typedef struct packed
	{
		logic [`DBS_DQ_W-1:0]  data;
		logic [`DBS_LANES-1:0] bw_n;
	} dbs_beat_s;

	typedef logic [`DBS_DQ_W-1:0] dbs_word_t;

endpackage

// ===== hdl/dbs_sync.sv
/*
 * two flip-flop synchroniser for a vector of pin levels.
 * assumes each bit is a level from outside the core clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module dbs_sync
#(
	parameter int W = 1
)
(
	// clock and reset
	input  wire logic         i_core_clk,
	input  wire logic         i_arst_n,
	// levels
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);

	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	always_ff @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			meta_reg <= '0;
			sync_reg <= '0;
		end
		else
		begin
			meta_reg <= i_async;
			sync_reg <= meta_reg;
		end
	end

	assign o_sync = sync_reg;

endmodule // dbs_sync

`default_nettype wire

// ===== hdl/dbs_fifo.sv
/*
 * valid/ready fifo with parameter width and depth (depth a power of two).
 * assumes a single clock; data out comes from the storage flip-flops.
 */
`timescale 1ns/1ps
`default_nettype none

module dbs_fifo
#(
	parameter int W     = 8,
	parameter int DEPTH = 8
)
(
	// clock and reset
	input  wire logic         i_core_clk,
	input  wire logic         i_arst_n,
	// fill side
	input  wire logic         i_in_valid,
	output logic              o_in_ready,
	input  wire logic [W-1:0] i_in_data,
	// drain side
	output logic              o_out_valid,
	input  wire logic         i_out_ready,
	output logic      [W-1:0] o_out_data
);

	localparam int AW = $clog2(DEPTH);

	logic [W-1:0]  mem_reg [DEPTH];
	logic [AW:0]   wr_ptr_reg;
	logic [AW:0]   rd_ptr_reg;
	logic          push;
	logic          pop;

	assign o_out_valid = wr_ptr_reg != rd_ptr_reg;
	assign o_in_ready  = (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0])
		|| (wr_ptr_reg[AW] == rd_ptr_reg[AW]);
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;
	assign o_out_data  = mem_reg[rd_ptr_reg[AW-1:0]];

	always_ff @(posedge i_core_clk)
	begin
		if (push)
			mem_reg[wr_ptr_reg[AW-1:0]] <= i_in_data;
	end

	always_ff @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
		end
	end

endmodule // dbs_fifo

`default_nettype wire

// ===== hdl/dbs_sram_if.sv
/*
 * device side of a double-data-rate sram with four-word linear bursts:
 * command capture, bus-cycle state machine, write beats with lane masks,
 * posted write with read bypass, buffered read delivery and echo strobes.
 * assumes all pins (reference clocks included) are slow against the core
 * clock and are sampled by it; the data pin is split into in, out, enable.
 */
`timescale 1ns/1ps
`default_nettype none

`include "dbs_consts.svh"

module dbs_sram_if
	import dbs_pkg::*;
(
	// clock and reset
	input  wire logic                   i_core_clk,
	input  wire logic                   i_arst_n,
	// reference clocks from the master
	input  wire logic                   i_in_ref,
	input  wire logic                   i_in_ref_inv,
	input  wire logic                   i_out_ref,
	input  wire logic                   i_out_ref_inv,
	// command and address
	input  wire logic                   i_load_strobe_n,
	input  wire logic                   i_read_write_select,
	input  wire logic [`DBS_ROW_W-1:0]  i_address_inputs,
	input  wire logic                   i_burst_start_bit_low,
	input  wire logic                   i_burst_start_bit_high,
	// data and lane masks
	input  wire logic [`DBS_LANES-1:0]  i_byte_lane_write_n,
	input  wire logic [`DBS_DQ_W-1:0]   i_dq,
	output logic      [`DBS_DQ_W-1:0]   o_dq,
	output logic                        o_dq_oe,
	// echo strobes
	output logic                        o_returned_strobe_true,
	output logic                        o_returned_strobe_inverse
);

	// replaces the lanes of a word whose bw_n bit is low
	function automatic dbs_word_t lane_merge
	(
		input dbs_word_t               old_w,
		input dbs_word_t               new_w,
		input logic [`DBS_LANES-1:0]   bw_n
	);
		dbs_word_t res;
		res = old_w;
		for (int l = 0; l < `DBS_LANES; l++)
		begin
			if (!bw_n[l])
				res[l*`DBS_LANE_W +: `DBS_LANE_W] =
					new_w[l*`DBS_LANE_W +: `DBS_LANE_W];
		end
		return res;
	endfunction

	// address of burst word idx, wrapping modulo four
	function automatic logic [`DBS_LO_W-1:0] burst_lo
	(
		input logic [`DBS_LO_W-1:0] start,
		input logic [`DBS_LO_W-1:0] idx
	);
		return `DBS_LO_W'(start + idx);
	endfunction

	// array index of a row and low bits
	function automatic logic [`DBS_ARR_AW-1:0] arr_idx
	(
		input logic [`DBS_ROW_W-1:0] row,
		input logic [`DBS_LO_W-1:0]  lo
	);
		return {row[`DBS_ARR_ROW_W-1:0], lo};
	endfunction

	// pin synchronisation
	logic [`DBS_SYNC_W-1:0]   pin_raw;
	logic [`DBS_SYNC_W-1:0]   pin_s;
	logic [3:0]               ref_s;
	logic [3:0]               ref_d_reg;
	logic [3:0]               ref_rise;
	logic                     ld_n_s;
	logic                     rw_s;
	logic [`DBS_ROW_W-1:0]    row_s;
	logic [`DBS_LO_W-1:0]     start_s;
	dbs_beat_s                beat_s;

	assign pin_raw = {i_in_ref, i_in_ref_inv, i_out_ref, i_out_ref_inv,
		i_load_strobe_n, i_read_write_select, i_address_inputs,
		i_burst_start_bit_high, i_burst_start_bit_low,
		i_dq, i_byte_lane_write_n};

	dbs_sync
	#(
		.W        (`DBS_SYNC_W)
	)
	u_sync
	(
		.i_core_clk (i_core_clk),
		.i_arst_n   (i_arst_n),
		.i_async    (pin_raw),
		.o_sync     (pin_s)
	);

	assign {ref_s, ld_n_s, rw_s, row_s, start_s, beat_s} = pin_s;

	always_ff @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			ref_d_reg <= 4'h0;
		else
			ref_d_reg <= ref_s;
	end

	assign ref_rise = ref_s & ~ref_d_reg;

	// edge events
	logic k_rise;
	logic kb_rise;
	logic use_in_ref;
	logic out_a_rise;
	logic out_b_rise;

	assign k_rise     = ref_rise[3];
	assign kb_rise    = ref_rise[2];
	// both output refs parked high: time reads from the input refs
	assign use_in_ref = ref_s[1] && ref_s[0]
		&& ref_d_reg[1] && ref_d_reg[0];
	assign out_a_rise = use_in_ref ? k_rise : ref_rise[1];
	assign out_b_rise = use_in_ref ? kb_rise : ref_rise[0];

	// bus-cycle state machine
	dbs_state_e state_reg;
	dbs_state_e state_next;
	logic       load_ok;
	logic       wr_cmd;
	logic       rd_cmd;

	// loads only when idle and strobe low; otherwise nop
	assign load_ok = k_rise && (state_reg == DBS_ST_IDLE)
		&& !ld_n_s;
	assign wr_cmd  = load_ok && !rw_s;
	assign rd_cmd  = load_ok && rw_s;

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			DBS_ST_IDLE:
			begin
				if (load_ok)
					state_next = rw_s ? DBS_ST_RD : DBS_ST_WR;
			end
			DBS_ST_WR,
			DBS_ST_RD:
			begin
				if (k_rise)
					state_next = DBS_ST_IDLE;
			end
			default:
				state_next = DBS_ST_IDLE;
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			state_reg <= DBS_ST_IDLE;
		else
			state_reg <= state_next;
	end

	// loaded command
	dbs_cmd_s cmd_reg;

	always_ff @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			cmd_reg <= '0;
		else if (load_ok)
			cmd_reg <= '{row: row_s, start: start_s, rd: rw_s};
	end

	// write beats into the posted write buffer
	dbs_beat_s            wbuf_reg [`DBS_BURST_LEN];
	dbs_cmd_s             pend_reg;
	logic                 pend_valid_reg;
	logic                 wr_busy_reg;
	logic [1:0]           wbeat_reg;
	logic                 beat_take;
	logic                 commit;

	assign beat_take = wr_busy_reg
		&& (wbeat_reg[0] ? kb_rise : k_rise);
	// the posted write goes to the array when the next write loads
	assign commit    = wr_cmd && pend_valid_reg;

	always_ff @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			wr_busy_reg    <= 1'b0;
			wbeat_reg      <= 2'h0;
			pend_valid_reg <= 1'b0;
			pend_reg       <= '0;
		end
		else if (wr_cmd)
		begin
			wr_busy_reg    <= 1'b1;
			wbeat_reg      <= 2'h1;
			pend_valid_reg <= 1'b0;
			pend_reg       <= '{row: row_s, start: start_s, rd: 1'b0};
		end
		else if (beat_take)
		begin
			wbeat_reg <= wbeat_reg + 2'h1;
			if (wbeat_reg == 2'h3)
			begin
				wr_busy_reg    <= 1'b0;
				pend_valid_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (wr_cmd)
			wbuf_reg[0] <= beat_s;
		else if (beat_take)
			wbuf_reg[wbeat_reg] <= beat_s;
	end

	// storage array
	dbs_word_t mem_reg [1 << `DBS_ARR_AW];

	always_ff @(posedge i_core_clk)
	begin
		if (commit)
		begin
			for (int i = 0; i < 4; i++)
			begin
				mem_reg[arr_idx(pend_reg.row,
					burst_lo(pend_reg.start, 2'(i)))] <=
					lane_merge(mem_reg[arr_idx(pend_reg.row,
					burst_lo(pend_reg.start, 2'(i)))],
					wbuf_reg[i].data, wbuf_reg[i].bw_n);
			end
		end
	end

	// read fetch into the data buffer
	logic                 fetch_busy_reg;
	logic [1:0]           fetch_idx_reg;
	logic [`DBS_LO_W-1:0] fetch_lo;
	logic [1:0]           pend_pos;
	logic                 pend_hit;
	dbs_word_t            fetch_word;
	logic                 fifo_in_ready;
	logic                 fifo_out_valid;
	logic                 fifo_pop;
	dbs_word_t            fifo_out_data;

	assign fetch_lo   = burst_lo(cmd_reg.start, fetch_idx_reg);
	assign pend_pos   = 2'(fetch_lo - pend_reg.start);
	assign pend_hit   = pend_valid_reg
		&& (pend_reg.row == cmd_reg.row);
	assign fetch_word = pend_hit
		? lane_merge(mem_reg[arr_idx(cmd_reg.row, fetch_lo)],
			wbuf_reg[pend_pos].data, wbuf_reg[pend_pos].bw_n)
		: mem_reg[arr_idx(cmd_reg.row, fetch_lo)];

	always_ff @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			fetch_busy_reg <= 1'b0;
			fetch_idx_reg  <= 2'h0;
		end
		else if (rd_cmd)
		begin
			fetch_busy_reg <= 1'b1;
			fetch_idx_reg  <= 2'h0;
		end
		else if (fetch_busy_reg && fifo_in_ready)
		begin
			fetch_idx_reg <= fetch_idx_reg + 2'h1;
			if (fetch_idx_reg == 2'h3)
				fetch_busy_reg <= 1'b0;
		end
	end

	dbs_fifo
	#(
		.W     (`DBS_DQ_W),
		.DEPTH (`DBS_FIFO_DEPTH)
	)
	u_rd_fifo
	(
		.i_core_clk  (i_core_clk),
		.i_arst_n    (i_arst_n),
		.i_in_valid  (fetch_busy_reg),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (fetch_word),
		.o_out_valid (fifo_out_valid),
		.i_out_ready (fifo_pop),
		.o_out_data  (fifo_out_data)
	);

	// read delivery on alternating output reference rises
	logic [1:0]  rbeat_reg;
	logic        out_edge;
	logic        any_out_edge;
	dbs_word_t   dq_reg;
	logic        dq_oe_reg;

	assign out_edge     = rbeat_reg[0] ? out_b_rise : out_a_rise;
	assign any_out_edge = out_a_rise || out_b_rise;
	assign fifo_pop     = out_edge && fifo_out_valid;

	always_ff @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			rbeat_reg <= 2'h0;
			dq_reg    <= '0;
			dq_oe_reg <= 1'b0;
		end
		else if (fifo_pop)
		begin
			rbeat_reg <= rbeat_reg + 2'h1;
			dq_reg    <= fifo_out_data;
			dq_oe_reg <= 1'b1;
		end
		else if (any_out_edge && rbeat_reg == 2'h0)
		begin
			dq_oe_reg <= 1'b0;
		end
	end

	assign o_dq    = dq_reg;
	assign o_dq_oe = dq_oe_reg;

	// echo strobes follow the output timing edges, never stop
	logic cq_reg;
	logic cqb_reg;

	always_ff @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			cq_reg  <= 1'b0;
			cqb_reg <= 1'b1;
		end
		else if (out_a_rise)
		begin
			cq_reg  <= 1'b1;
			cqb_reg <= 1'b0;
		end
		else if (out_b_rise)
		begin
			cq_reg  <= 1'b0;
			cqb_reg <= 1'b1;
		end
	end

	assign o_returned_strobe_true    = cq_reg;
	assign o_returned_strobe_inverse = cqb_reg;

endmodule // dbs_sram_if

`default_nettype wire

// ===== testbench/dbs_sram_if_checker.sv
/*
 * pin assertions: echo strobes, read window, data drive.
 * assumes a bind to dbs_sram_if; pins move on core falling edges.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dbs_consts.svh"
module dbs_sram_if_checker
	import dbs_pkg::*;
(
	// clock and reset
	input	wire logic			i_core_clk,
	input	wire logic			i_arst_n,
	// watched pins
	input	wire logic			i_in_ref,
	input	wire logic			i_out_ref,
	input	wire logic			i_out_ref_inv,
	input	wire logic			i_load_strobe_n,
	input	wire logic			i_read_write_select,
	input	wire logic [`DBS_DQ_W-1:0]	o_dq,
	input	wire logic			o_dq_oe,
	input	wire logic			o_returned_strobe_true,
	input	wire logic			o_returned_strobe_inverse
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n);
	// cycles since a read was loaded, saturating
	logic [5:0]	since_rd_reg;
	always_ff @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			since_rd_reg <= 6'h3F;
		else if (!i_load_strobe_n && i_read_write_select && i_in_ref)
			since_rd_reg <= 6'h00;
		else if (since_rd_reg != 6'h3F)
			since_rd_reg <= since_rd_reg + 6'h01;
	end
	sequence s_drive8;
		o_dq_oe [*8];
	endsequence
	sequence s_refs_still;
		(!(i_out_ref && i_out_ref_inv) && $stable(i_out_ref)
			&& $stable(i_out_ref_inv)) [*6];
	endsequence
	a_oe_reset: assert property (
		$rose(i_arst_n) |-> !o_dq_oe && o_returned_strobe_inverse)
		else $error("drive or strobe wrong after reset");
	a_strobe_pair: assert property (
		o_returned_strobe_true != o_returned_strobe_inverse)
		else $error("echo strobes not complementary");
	a_strobe_true_edge: assert property (
		$rose(i_out_ref) && !i_out_ref_inv
			|-> ##[1:4] o_returned_strobe_true)
		else $error("true strobe missed its edge");
	a_strobe_inv_edge: assert property (
		$rose(i_out_ref_inv) && !i_out_ref
			|-> ##[1:4] o_returned_strobe_inverse)
		else $error("inverse strobe missed its edge");
	a_strobe_quiet: assert property (
		s_refs_still |-> $stable(o_returned_strobe_true))
		else $error("strobe moved without an edge");
	a_first_word: assert property (
		$rose(o_dq_oe) |-> $rose(o_returned_strobe_true))
		else $error("first read word off a true edge");
	a_word_hold: assert property (
		o_dq_oe && $past(o_dq_oe) && $stable(o_returned_strobe_true)
			|-> $stable(o_dq))
		else $error("read word changed between edges");
	a_burst_len: assert property (
		$rose(o_dq_oe) |-> s_drive8 ##1 s_drive8)
		else $error("read burst shorter than four words");
	a_oe_release: assert property (
		$fell(o_dq_oe) |-> $rose(o_returned_strobe_true))
		else $error("drive released off a true edge");
	a_drive_cause: assert property (
		o_dq_oe |-> since_rd_reg < 6'h28)
		else $error("data driven without a read");
endmodule // dbs_sram_if_checker
bind dbs_sram_if dbs_sram_if_checker dbs_sram_if_checker_i
(
	.i_core_clk, .i_arst_n, .i_in_ref, .i_out_ref, .i_out_ref_inv,
	.i_load_strobe_n, .i_read_write_select, .o_dq, .o_dq_oe,
	.o_returned_strobe_true, .o_returned_strobe_inverse
);
`default_nettype wire

// ===== testbench/dbs_master_model.sv
/*
 * bus master model: reference clocks, commands, write beats.
 * assumes tasks are called from the bench; pins move on falling edges.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dbs_consts.svh"
module dbs_master_model
	import dbs_pkg::*;
(
	// time base
	input	wire logic	i_core_clk,
	// pins toward the device
	output	var logic	o_in_ref,
	output	var logic	o_in_ref_inv,
	output	var logic	o_out_ref,
	output	var logic	o_out_ref_inv,
	output	var logic	o_load_strobe_n,
	output	var dbs_cmd_s	o_cmd,
	output	var dbs_beat_s	o_beat
);
	logic	k_mode;
	initial
	begin
		k_mode = 1'b0;
		o_in_ref = 1'b0;
		o_in_ref_inv = 1'b0;
		o_out_ref = 1'b0;
		o_out_ref_inv = 1'b0;
		o_load_strobe_n = 1'b1;
		o_cmd = '0;
		o_beat = '1;
	end
	// half period: pins settle mid-half, then references flip
	task automatic half(input logic ld_n, input dbs_cmd_s c,
		input dbs_beat_s b);
		repeat (2) @(negedge i_core_clk);
		o_load_strobe_n = ld_n;
		o_cmd = c;
		o_beat = b;
		repeat (2) @(negedge i_core_clk);
		o_in_ref = ~o_in_ref;
		o_in_ref_inv = ~o_in_ref;
		if (!k_mode)
		begin
			o_out_ref = o_in_ref;
			o_out_ref_inv = o_in_ref_inv;
		end
	endtask
	// whole access; bump loads a stray command mid-burst
	task automatic burst(input dbs_cmd_s c, input dbs_beat_s b [4],
		input logic bump);
		dbs_beat_s	idle;
		dbs_cmd_s	junk;
		idle = '{data: ~o_beat.data, bw_n: 4'hF};
		junk = ~c;
		half(1'b0, c, c.rd ? idle : b[0]);
		half(1'b1, junk, c.rd ? idle : b[1]);
		half(!bump, junk, c.rd ? idle : b[2]);
		half(1'b1, junk, c.rd ? idle : b[3]);
		if (c.rd)
			repeat (4) half(1'b1, junk, idle);
		repeat (4) @(negedge i_core_clk);
		o_beat.data = ~o_beat.data;
		o_in_ref_inv = 1'b0;
		if (!k_mode)
			o_out_ref_inv = 1'b0;
	endtask
	// both output references high selects input timing
	task automatic set_k(input logic on);
		k_mode = on;
		o_out_ref = on;
		o_out_ref_inv = on;
		repeat (8) @(negedge i_core_clk);
	endtask
endmodule // dbs_master_model
`default_nettype wire

// ===== testbench/dbs_sram_if_bench.sv
/*
 * self-checking bench for dbs_sram_if and its read buffer.
 * assumes the master model drives every device pin except clock and reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dbs_consts.svh"
module dbs_sram_if_bench
	import dbs_pkg::*;
;
	logic		clk, arst_n, in_ref, in_ref_inv, out_ref, out_ref_inv;
	logic		ld_n, dq_oe, st_t, st_i, st_q;
	dbs_cmd_s	cmd;
	dbs_beat_s	beat;
	dbs_word_t	dq_out, dq_pin;
	dbs_word_t	got[$];
	dbs_word_t	exp_mem[16][4];
	int		n_fail, checked;
	// the shared data pin: device wins while it drives
	assign dq_pin = dq_oe ? dq_out : beat.data;
	dbs_master_model dbs_master_model_i
	(
		.i_core_clk(clk), .o_in_ref(in_ref), .o_in_ref_inv(in_ref_inv),
		.o_out_ref(out_ref), .o_out_ref_inv(out_ref_inv),
		.o_load_strobe_n(ld_n), .o_cmd(cmd), .o_beat(beat)
	);
	dbs_sram_if dbs_sram_if_i
	(
		.i_core_clk(clk), .i_arst_n(arst_n),
		.i_in_ref(in_ref), .i_in_ref_inv(in_ref_inv),
		.i_out_ref(out_ref), .i_out_ref_inv(out_ref_inv),
		.i_load_strobe_n(ld_n), .i_read_write_select(cmd.rd),
		.i_address_inputs(cmd.row),
		.i_burst_start_bit_low(cmd.start[0]),
		.i_burst_start_bit_high(cmd.start[1]),
		.i_byte_lane_write_n(beat.bw_n), .i_dq(dq_pin),
		.o_dq(dq_out), .o_dq_oe(dq_oe),
		.o_returned_strobe_true(st_t), .o_returned_strobe_inverse(st_i)
	);
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// a new read word shows as a strobe change while driving
	always @(posedge clk)
	begin
		if (dq_oe === 1'b1 && st_t !== st_q)
			got.push_back(dq_out);
		st_q <= st_t;
	end
	task automatic check(input dbs_word_t seen, input dbs_word_t want);
		checked++;
		if (seen !== want)
		begin
			n_fail++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic wr(input logic [3:0] row, input logic [1:0] s,
		input dbs_word_t base, input logic [15:0] m, input logic bump);
		dbs_beat_s	b [4];
		logic [1:0]	lo;
		for (int i = 0; i < 4; i++)
		begin
			b[i] = '{data: base ^ dbs_word_t'(i), bw_n: m[4*i+:4]};
			lo = s + 2'(i);
			for (int l = 0; l < `DBS_LANES; l++)
				if (!m[4*i+l])
					exp_mem[row][lo][9*l+:9] = b[i].data[9*l+:9];
		end
		dbs_master_model_i.burst('{17'(row), s, 1'b0}, b, bump);
	endtask
	task automatic rd(input logic [3:0] row, input logic [1:0] s);
		dbs_beat_s	b [4];
		int		k;
		b = '{default: '1};
		got.delete();
		dbs_master_model_i.burst('{17'(row), s, 1'b1}, b, 1'b0);
		for (k = 0; k < 40 && dq_oe !== 1'b0; k++)
			@(negedge clk);
		if (k == 40)
		begin
			n_fail++;
			end_sim();
		end
		check(dbs_word_t'(got.size()), 36'h4);
		for (int i = 0; i < 4; i++)
			check(got[i], exp_mem[row][s+2'(i)]);
	endtask
	task automatic t_reset;
		arst_n = 1'b0;
		repeat (8) @(negedge clk);
		check(dbs_word_t'({dq_oe, st_t, st_i}), 36'h1);
		arst_n = 1'b1;
		repeat (8) @(negedge clk);
	endtask
	task automatic t_nop;
		logic	st0;
		got.delete();
		repeat (4) dbs_master_model_i.half(1'b1, '0, beat);
		repeat (8) @(negedge clk);
		st0 = st_t;
		repeat (40) @(negedge clk);
		check(dbs_word_t'({got.size() == 0, st_t === st0}), 36'h3);
	endtask
	// read buffer exercised through the device pins after idle time
	task automatic t_fifo;
		rd(4'h2, 2'h1);
		check(dbs_word_t'(dq_oe), 36'h0);
		check(dbs_word_t'(got.size()), 36'h4);
		check(got[0], exp_mem[2][1]);
	endtask
	initial
	begin
		n_fail = 0;
		checked = 0;
		arst_n = 1'b0;
		t_reset();
		wr(4'h1, 2'h2, 36'h1_2345_6789, 16'h0000, 1'b1);
		rd(4'h1, 2'h2);
		wr(4'h2, 2'h0, 36'hA_BCDE_F012, 16'h0000, 1'b0);
		rd(4'h1, 2'h1);
		wr(4'h1, 2'h0, 36'h5_5AA5_C33C, 16'h7BDE, 1'b0);
		rd(4'h1, 2'h3);
		wr(4'h3, 2'h1, 36'hF_0F0F_0F0F, 16'hFFFF, 1'b0);
		rd(4'h1, 2'h0);
		dbs_master_model_i.set_k(1'b1);
		rd(4'h2, 2'h3);
		dbs_master_model_i.set_k(1'b0);
		t_nop();
		t_fifo();
		end_sim();
	end
endmodule // dbs_sram_if_bench
`default_nettype wire
